/* File: common/pbm_map.vh */
/*
 * constants of the basic mode control register: management address,
 * field positions, reset value, frame layout and timing counts.
 * assumes a 125 MHz system clock and clause-22 style management frames.
 */
`ifndef PBM_MAP_VH
`define PBM_MAP_VH

// register address inside the device
`define PBM_CTRL_OFFSET 5'h00
// value after reset, auto-negotiation strap not yet applied
`define PBM_CTRL_RESET 16'h3100

// field positions
`define PBM_BIT_SRESET 15
`define PBM_BIT_LOOP 14
`define PBM_BIT_SPEED 13
`define PBM_BIT_ANEN 12
`define PBM_BIT_PWDN 11
`define PBM_BIT_ISO 10
`define PBM_BIT_RESTART 9
`define PBM_BIT_DUPLEX 8
`define PBM_BIT_COLTEST 7
`define PBM_RSVD_MSB 6

// length of a software reset in clock cycles
`define PBM_SRESET_CYCLES 8'h10
// cycle after reset release at which the strap is taken
`define PBM_STRAP_AT 2'h2

// management frame layout
`define PBM_PREAMBLE_LEN 6'h20
`define PBM_HDR_LAST 4'hC
`define PBM_DATA_LAST 4'hF
`define PBM_OP_READ 2'h2
`define PBM_OP_WRITE 2'h1

// collision test timing: bit times, ns, derived cycle bounds
`define PBM_CLK_NS 8
`define PBM_BIT_NS_100 10
`define PBM_COL_ON_BITS 512
`define PBM_COL_OFF_BITS 4
`define PBM_COL_ON_CYC ((`PBM_COL_ON_BITS * `PBM_BIT_NS_100) / `PBM_CLK_NS)
`define PBM_COL_OFF_CYC ((`PBM_COL_OFF_BITS * `PBM_BIT_NS_100) / `PBM_CLK_NS)

`endif

/* File: core/pbm_mdio_slave.v */
/*
 * serial management frame engine: finds preamble, decodes the header,
 * shifts read data out and write data in for one register address.
 * assumes mdc edges and mdio level already synchronised by the caller.
 */
`timescale 1ns/1ps
`include "pbm_map.vh"
`default_nettype none

module pbm_mdio_slave #(
    parameter [4:0] PHY_ADDR = 5'h00
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // synchronised management line
    input  wire        mdc_rise,
    input  wire        mdio_s,
    // register side
    input  wire [15:0] reg_rdata,
    output reg         wr_stb,
    output reg  [15:0] wr_data,
    // management data drive
    output reg         mdio_out,
    output reg         mdio_oe
);

    // frame states
    localparam [1:0] S_PRE = 2'h0;
    localparam [1:0] S_HDR = 2'h1;
    localparam [1:0] S_TA  = 2'h2;
    localparam [1:0] S_DAT = 2'h3;

    reg [1:0]  state;    // frame position
    reg [5:0]  pre_cnt;  // consecutive ones seen
    reg [3:0]  bit_cnt;  // bit within header, turnaround or data
    reg [11:0] hdr;      // header bits collected so far
    reg [15:0] shift;    // data shifter, both directions
    reg        rd_mode;  // read aimed at this register
    reg        wr_mode;  // write aimed at this register
    wire [12:0] hdr_full; // header including the bit on the line now

    assign hdr_full = {hdr, mdio_s};

    // everything moves on the rising mdc edge; the host samples on the
    // next rising edge, so driving right after an edge gives a full period
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= S_PRE;
            pre_cnt  <= 6'h00;
            bit_cnt  <= 4'h0;
            hdr      <= 12'h000;
            shift    <= 16'h0000;
            rd_mode  <= 1'b0;
            wr_mode  <= 1'b0;
            wr_stb   <= 1'b0;
            wr_data  <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    S_PRE: begin
                        if (mdio_s) begin
                            // saturate so long idle lines do not wrap
                            if (pre_cnt != `PBM_PREAMBLE_LEN)
                                pre_cnt <= pre_cnt + 6'h01;
                        end else begin
                            // zero after full preamble is the start bit
                            if (pre_cnt == `PBM_PREAMBLE_LEN) begin
                                state   <= S_HDR;
                                bit_cnt <= 4'h0;
                                hdr     <= 12'h000;
                            end
                            pre_cnt <= 6'h00;
                        end
                    end
                    S_HDR: begin
                        hdr     <= hdr_full[11:0];
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `PBM_HDR_LAST) begin
                            bit_cnt <= 4'h0;
                            rd_mode <= hdr_full[12] && hdr_full[9:5] == PHY_ADDR
                                && hdr_full[4:0] == `PBM_CTRL_OFFSET
                                && hdr_full[11:10] == `PBM_OP_READ;
                            wr_mode <= hdr_full[12] && hdr_full[9:5] == PHY_ADDR
                                && hdr_full[4:0] == `PBM_CTRL_OFFSET
                                && hdr_full[11:10] == `PBM_OP_WRITE;
                            // a broken start or other address just waits out
                            state   <= S_TA;
                        end
                    end
                    S_TA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h0) begin
                            // second turnaround bit is driven low on reads
                            mdio_oe  <= rd_mode;
                            mdio_out <= 1'b0;
                        end else begin
                            state    <= S_DAT;
                            bit_cnt  <= 4'h0;
                            // latest register value is taken here
                            mdio_out <= reg_rdata[15] & rd_mode;
                            shift    <= {reg_rdata[14:0], 1'b0};
                        end
                    end
                    default: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (rd_mode) begin
                            mdio_out <= shift[15];
                            shift    <= {shift[14:0], 1'b0};
                        end else begin
                            shift <= {shift[14:0], mdio_s};
                        end
                        if (bit_cnt == `PBM_DATA_LAST) begin
                            state   <= S_PRE;
                            mdio_oe <= 1'b0;
                            wr_stb  <= wr_mode;
                            wr_data <= {shift[14:0], mdio_s};
                        end
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: core/pbm_basic_mode_control.v */
/*
 * basic mode control register of a 10/100 ethernet transceiver, reached
 * over the serial management pins, with its control outputs.
 * assumes an auto-negotiation engine, pcs and mac data path outside that
 * consume the control levels; pins arrive asynchronous to clk.
 */
// Operation
// - top bit runs self-clearing pcs software reset
// - loopback bit returns mac transmit to receive
// - speed bit picks 10 or 100, resets one
// - negotiation enable, strap default, overrides speed/duplex
// - negotiation off: only bits 8, 13 rule
// - power-down stops all but register access
// - low sleep pin powers down, sets bit
// - isolate bit cuts mac data interface
// - isolated clock master stops reference clock
// - restart writes ignored while negotiation disabled
// - restart bit reads one until negotiation starts
// - writing zero never stops running negotiation
// - duplex bit picks half or full, resets one
// - collision test raises col after tx enable
// - collision test drops col after tx enable falls
`timescale 1ns/1ps
`include "pbm_map.vh"
`default_nettype none

module pbm_basic_mode_control #(
    parameter [4:0] PHY_ADDR = 5'h00
) (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // serial management pins
    input  wire mdc,
    input  wire mdio_in,
    output wire mdio_out,
    output wire mdio_oe,
    // straps and pins
    input  wire irq_or_sleep_pin_n,
    input  wire negotiation_off_strap,
    input  wire rmii_master_strap,
    input  wire tx_en,
    // auto-negotiation engine
    input  wire an_started,
    input  wire an_speed_100,
    input  wire an_full_duplex,
    output reg  an_enable,
    output reg  an_restart,
    // pcs and mac path control
    output reg  pcs_soft_reset,
    output reg  mac_loopback,
    output reg  link_speed_100,
    output reg  link_full_duplex,
    output reg  power_down,
    output reg  mac_isolate,
    output reg  ref_clk_enable,
    output reg  col
);

    // pin synchronisers: stage one feeds stage two only
    reg [5:0] sync1;       // first stage of mdc, mdio, pin, straps, tx_en
    reg [5:0] sync2;       // second stage, safe to read
    reg       mdc_last;    // previous synchronised mdc level
    wire      mdc_s;       // synchronised management clock
    wire      mdio_s;      // synchronised management data
    wire      sleep_low_s; // sleep pin held low
    wire      strap_s;     // negotiation-off strap level
    wire      master_s;    // reference clock master strap level
    wire      tx_en_s;     // synchronised transmit enable
    wire      mdc_rise;    // one-cycle rising edge of mdc

    // register fields
    reg       f_loop;      // loopback
    reg       f_speed;     // manual speed, 1 = 100
    reg       f_anen;      // negotiation enable
    reg       f_pwdn;      // power-down bit
    reg       f_iso;       // isolate
    reg       f_restart;   // restart pending
    reg       f_duplex;    // manual duplex, 1 = full
    reg       f_coltest;   // collision test
    reg [7:0] sreset_cnt;  // software reset cycles left
    reg       strap_val;   // strap taken after reset release
    reg [1:0] strap_cnt;   // cycles since reset release
    wire [15:0] ctrl_dflt = `PBM_CTRL_RESET; // defaults for a software reset

    // next values of the fields
    reg       next_loop;
    reg       next_speed;
    reg       next_anen;
    reg       next_pwdn;
    reg       next_iso;
    reg       next_restart;
    reg       next_duplex;
    reg       next_coltest;
    reg [7:0] next_sreset_cnt;
    reg       next_an_restart;

    // management engine interface
    wire        wr_stb;    // one-cycle write strobe
    wire [15:0] wr_data;   // written word
    wire [15:0] rd_word;   // word the station reads
    wire        sreset_busy;
    wire        pwdn_any;

    // read-back word; reserved bits read as zero
    function [15:0] pbm_pack;
        input       busy;
        input [7:0] f;
        begin
            pbm_pack = {busy, f, {(`PBM_RSVD_MSB + 1){1'b0}}};
        end
    endfunction

    assign mdc_s       = sync2[0];
    assign mdio_s      = sync2[1];
    assign sleep_low_s = ~sync2[2];
    assign strap_s     = sync2[3];
    assign master_s    = sync2[4];
    assign tx_en_s     = sync2[5];
    assign mdc_rise    = mdc_s & ~mdc_last;
    assign sreset_busy = (sreset_cnt != 8'h00);
    assign pwdn_any    = f_pwdn | sleep_low_s;
    assign rd_word     = pbm_pack(sreset_busy, {f_loop, f_speed, f_anen,
                                  f_pwdn, f_iso, f_restart, f_duplex,
                                  f_coltest});

    // two-flop synchronisers and mdc edge memory
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1    <= 6'h04;
            sync2    <= 6'h04;
            mdc_last <= 1'b0;
        end else begin
            sync1    <= {tx_en, rmii_master_strap, negotiation_off_strap,
                         irq_or_sleep_pin_n, mdio_in, mdc};
            sync2    <= sync1;
            mdc_last <= mdc_s;
        end
    end

    // strap is caught once the synchroniser holds a real sample, never
    // from the asynchronous reset itself
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_cnt <= 2'h0;
            strap_val <= 1'b0;
        end else begin
            if (strap_cnt != 2'h3)
                strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `PBM_STRAP_AT)
                strap_val <= strap_s;
        end
    end

    // next-state of the register fields
    always @* begin
        next_loop       = f_loop;
        next_speed      = f_speed;
        next_anen       = f_anen;
        next_pwdn       = f_pwdn;
        next_iso        = f_iso;
        next_restart    = f_restart;
        next_duplex     = f_duplex;
        next_coltest    = f_coltest;
        next_sreset_cnt = sreset_cnt;
        next_an_restart = 1'b0;
        if (strap_cnt == `PBM_STRAP_AT) begin
            // strap overrides the default enable
            next_anen = ~strap_s;
        end
        if (sreset_busy) begin
            // reset in progress: count down, writes are not taken
            next_sreset_cnt = sreset_cnt - 8'h01;
        end else if (wr_stb) begin
            if (wr_data[`PBM_BIT_SRESET]) begin
                // pcs fields back to default, strap kept
                next_sreset_cnt = `PBM_SRESET_CYCLES;
                next_loop    = ctrl_dflt[`PBM_BIT_LOOP];
                next_speed   = ctrl_dflt[`PBM_BIT_SPEED];
                next_anen    = ~strap_val;
                next_pwdn    = ctrl_dflt[`PBM_BIT_PWDN];
                next_iso     = ctrl_dflt[`PBM_BIT_ISO];
                next_restart = 1'b0;
                next_duplex  = ctrl_dflt[`PBM_BIT_DUPLEX];
                next_coltest = ctrl_dflt[`PBM_BIT_COLTEST];
            end else begin
                next_loop    = wr_data[`PBM_BIT_LOOP];
                next_speed   = wr_data[`PBM_BIT_SPEED];
                next_anen    = wr_data[`PBM_BIT_ANEN];
                next_pwdn    = wr_data[`PBM_BIT_PWDN];
                next_iso     = wr_data[`PBM_BIT_ISO];
                next_duplex  = wr_data[`PBM_BIT_DUPLEX];
                next_coltest = wr_data[`PBM_BIT_COLTEST];
                // a zero leaves a pending restart alone
                if (wr_data[`PBM_BIT_RESTART] && wr_data[`PBM_BIT_ANEN]) begin
                    next_restart    = 1'b1;
                    next_an_restart = 1'b1;
                end
            end
        end
        // engine has picked up the restart: bit clears itself, but a
        // restart written in the same cycle stays pending
        if (an_started && !next_an_restart)
            next_restart = 1'b0;
        // nothing to restart while negotiation is off
        if (!next_anen) begin
            next_restart    = 1'b0;
            next_an_restart = 1'b0;
        end
        // the low pin sets the bit and beats any write of zero
        if (sleep_low_s)
            next_pwdn = 1'b1;
    end

    // field flops
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            f_loop     <= 1'b0;
            f_speed    <= 1'b1;
            f_anen     <= 1'b1;
            f_pwdn     <= 1'b0;
            f_iso      <= 1'b0;
            f_restart  <= 1'b0;
            f_duplex   <= 1'b1;
            f_coltest  <= 1'b0;
            sreset_cnt <= 8'h00;
        end else begin
            f_loop     <= next_loop;
            f_speed    <= next_speed;
            f_anen     <= next_anen;
            f_pwdn     <= next_pwdn;
            f_iso      <= next_iso;
            f_restart  <= next_restart;
            f_duplex   <= next_duplex;
            f_coltest  <= next_coltest;
            sreset_cnt <= next_sreset_cnt;
        end
    end

    // registered control outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            an_enable        <= 1'b1;
            an_restart       <= 1'b0;
            pcs_soft_reset   <= 1'b0;
            mac_loopback     <= 1'b0;
            link_speed_100   <= 1'b1;
            link_full_duplex <= 1'b1;
            power_down       <= 1'b0;
            mac_isolate      <= 1'b0;
            ref_clk_enable   <= 1'b1;
        end else begin
            an_enable      <= f_anen;
            // restart pulse is not sent into a powered-down engine
            an_restart     <= next_an_restart & ~pwdn_any;
            pcs_soft_reset <= sreset_busy;
            mac_loopback   <= f_loop & ~pwdn_any;
            // manual bits only count with negotiation off
            if (f_anen) begin
                link_speed_100   <= an_speed_100;
                link_full_duplex <= an_full_duplex;
            end else begin
                link_speed_100   <= f_speed;
                link_full_duplex <= f_duplex;
            end
            power_down  <= pwdn_any;
            mac_isolate <= f_iso;
            // only the clock master owns the reference clock
            ref_clk_enable <= ~(f_iso & master_s);
        end
    end

    // collision test: sync plus one flop gives 3 cycles (24 ns) each way,
    // well inside both the on bound and the 4 bit-time off bound at 100M
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            col <= 1'b0;
        end else begin
            col <= f_coltest & tx_en_s & ~f_iso & ~pwdn_any;
        end
    end

    // frame engine; keeps running through power-down and isolation
    pbm_mdio_slave #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .clk       (clk),
        .rst       (rst),
        .mdc_rise  (mdc_rise),
        .mdio_s    (mdio_s),
        .reg_rdata (rd_word),
        .wr_stb    (wr_stb),
        .wr_data   (wr_data),
        .mdio_out  (mdio_out),
        .mdio_oe   (mdio_oe)
    );

endmodule

`default_nettype wire

/* File: testbench/pbm_mgmt_station.sv */
/* management station model: makes mdc and whole mdio frames.
   assumes a pull-up on mdio and the device clock as time base. */
`timescale 1ns/1ps
`include "pbm_map.vh"
`default_nettype none
module pbm_mgmt_station (
    // time base
    input  wire logic clk,
    // device drive of mdio
    input  wire logic dev_oe,
    input  wire logic dev_out,
    // management pins
    output var  logic mdc,
    output wire logic mdio_line
);
    logic sta_oe  = 1'h0; // station drives mdio
    logic sta_out = 1'h1; // station data bit
    initial mdc = 1'h0;
    // pull-up wins when nobody drives, so a stale bit never lingers
    assign mdio_line = dev_oe ? dev_out : (sta_oe ? sta_out : 1'h1);
    // one mdc period of 8 clocks; sample just before the rise
    task tick(input logic b, output logic s);
        sta_out <= b;
        repeat (3) @(posedge clk);
        #1 s = mdio_line;
        @(posedge clk) mdc <= 1'h1;
        repeat (4) @(posedge clk);
        mdc <= 1'h0;
    endtask
    // whole frame with a fresh preamble; mdc idles low afterwards
    task frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
               output logic [15:0] rv);
        logic [63:0] seq;
        logic        s;
        seq = {32'hFFFFFFFF, 2'h1, rd ? `PBM_OP_READ : `PBM_OP_WRITE, 5'h00, ra, 2'h2, wd};
        sta_oe <= 1'h1;
        for (int i = 63; i >= 0; i--) begin
            // release the line for turnaround on reads
            if (rd && i == 17) begin
                sta_oe <= 1'h0;
            end
            tick(seq[i], s);
            rv = {rv[14:0], s};
        end
        sta_oe <= 1'h0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/pbm_bmc_props.sv */
/* checker for the control outputs of the basic mode control register.
   assumes only the top module ports; bound after the module. */
`timescale 1ns/1ps
`default_nettype none
module pbm_bmc_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and engine result
    input wire logic irq_or_sleep_pin_n,
    input wire logic rmii_master_strap,
    input wire logic tx_en,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    // control outputs
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic pcs_soft_reset,
    input wire logic mac_loopback,
    input wire logic link_speed_100,
    input wire logic link_full_duplex,
    input wire logic power_down,
    input wire logic mac_isolate,
    input wire logic ref_clk_enable,
    input wire logic col
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] run_len; // cycles the current software reset has stood
    // length counter, since a repetition cannot span 16 cycles cheaply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_len <= 8'h00;
        end else begin
            run_len <= pcs_soft_reset ? run_len + 8'h01 : 8'h00;
        end
    end
    sreset_len_a: assert property ($fell(pcs_soft_reset) |-> run_len == 8'h10)
        else $error("software reset length wrong");
    sleep_pin_a: assert property ((!irq_or_sleep_pin_n) [*5] |-> power_down)
        else $error("pin low without power-down");
    sleep_quiet_a: assert property (power_down [*2] |-> !mac_loopback && !an_restart)
        else $error("activity during power-down");
    col_cause_a: assert property (col |-> $past(tx_en, 2) || $past(tx_en, 3))
        else $error("collision without transmit");
    col_drop_a: assert property ((!tx_en) [*5] |-> !col)
        else $error("collision held too long");
    ref_clk_a: assert property ((mac_isolate && rmii_master_strap) [*4] |-> !ref_clk_enable)
        else $error("reference clock still on");
    neg_result_a: assert property ((an_enable && $stable(an_speed_100) && $stable(an_full_duplex))
        [*3] |-> link_speed_100 == an_speed_100 && link_full_duplex == an_full_duplex)
        else $error("negotiated result not used");
    restart_gate_a: assert property (an_restart |-> ##1 an_enable)
        else $error("restart while disabled");
    restart_once_a: assert property (an_restart |=> !an_restart)
        else $error("restart pulse too long");
    cover property (col);
    cover property ($rose(pcs_soft_reset));
    cover property (an_restart);
endmodule
bind pbm_basic_mode_control pbm_bmc_props u_props (
    .clk(clk), .rst(rst), .irq_or_sleep_pin_n(irq_or_sleep_pin_n),
    .rmii_master_strap(rmii_master_strap), .tx_en(tx_en), .an_speed_100(an_speed_100),
    .an_full_duplex(an_full_duplex), .an_enable(an_enable), .an_restart(an_restart),
    .pcs_soft_reset(pcs_soft_reset), .mac_loopback(mac_loopback),
    .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex),
    .power_down(power_down), .mac_isolate(mac_isolate), .ref_clk_enable(ref_clk_enable),
    .col(col)
);
`default_nettype wire

/* File: testbench/tb_pbm_basic_mode_control.sv */
/* self-checking bench for the basic mode control register.
   assumes the station model and the register map header. */
`timescale 1ns/1ps
`include "pbm_map.vh"
`default_nettype none
module tb_pbm_basic_mode_control;
    // bench driven inputs
    logic        clk                   = 1'h0;
    logic        rst                   = 1'h1;
    logic        irq_or_sleep_pin_n    = 1'h1;
    logic        negotiation_off_strap = 1'h0;
    logic        rmii_master_strap     = 1'h1;
    logic        tx_en                 = 1'h0;
    logic        an_started            = 1'h0;
    logic        an_speed_100          = 1'h0;
    logic        an_full_duplex        = 1'h0;
    // device outputs and management line
    logic        mdc, mdio_line, mdio_out, mdio_oe, an_enable, an_restart, pcs_soft_reset;
    logic        mac_loopback, link_speed_100, link_full_duplex, power_down, mac_isolate;
    logic        ref_clk_enable, col;
    // bookkeeping
    int          num_errors  = 0;
    int          comparisons = 0;
    int          restarts    = 0;
    int          sr_cycles   = 0;
    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] rd;
        logic [5:0]  outs;
    } pbm_row_t;
    // write, readback, {negotiate, speed, duplex, loopback, isolate, ref clock}
    pbm_row_t rows [8] = '{
        '{16'h0000, 16'h0000, 6'h01}, '{16'h2100, 16'h2100, 6'h19},
        '{16'h2000, 16'h2000, 6'h11}, '{16'h0100, 16'h0100, 6'h09},
        '{16'h3100, 16'h3100, 6'h21}, '{16'h407F, 16'h4000, 6'h05},
        '{16'h0400, 16'h0400, 6'h02}, '{16'h0200, 16'h0000, 6'h01}};
    always #4 clk = ~clk;
    pbm_mgmt_station u_sta (.clk(clk), .dev_oe(mdio_oe), .dev_out(mdio_out), .mdc(mdc),
        .mdio_line(mdio_line));
    pbm_basic_mode_control dut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_or_sleep_pin_n(irq_or_sleep_pin_n),
        .negotiation_off_strap(negotiation_off_strap), .rmii_master_strap(rmii_master_strap),
        .tx_en(tx_en), .an_started(an_started), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_enable(an_enable), .an_restart(an_restart),
        .pcs_soft_reset(pcs_soft_reset), .mac_loopback(mac_loopback),
        .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex),
        .power_down(power_down), .mac_isolate(mac_isolate),
        .ref_clk_enable(ref_clk_enable), .col(col));
    // count restart pulses and software reset cycles
    always @(posedge clk) begin
        if (an_restart === 1'h1) restarts <= restarts + 1;
        if (pcs_soft_reset === 1'h1) sr_cycles <= sr_cycles + 1;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // write, then let the fields land; ends 1 ns past an edge
    task wr_at(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] junk;
        @(posedge clk);
        u_sta.frame(1'h0, ra, wd, junk);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task rchk(input logic [4:0] ra, input logic [15:0] exp, input string what);
        logic [15:0] v;
        @(posedge clk);
        u_sta.frame(1'h1, ra, 16'h0000, v);
        #1;
        chk(v, exp, what);
    endtask
    task results();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog: about thirty frames of 512 cycles should suffice
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        chk({an_enable, link_speed_100, link_full_duplex, ref_clk_enable, mac_loopback,
            power_down}, 16'h003C, "reset levels");
        rst <= 1'h0;
        repeat (6) @(posedge clk);
        rchk(`PBM_CTRL_OFFSET, 16'h3100, "reset value");
        foreach (rows[k]) begin
            // address 5'h16 is written first; the device answers only address 0, so loopback does not depend on it
            if (k == 5) begin
                wr_at(5'h16, 16'h0004);
            end
            wr_at(`PBM_CTRL_OFFSET, rows[k].wr);
            rchk(`PBM_CTRL_OFFSET, rows[k].rd, "row readback");
            chk({an_enable, link_speed_100, link_full_duplex, mac_loopback, mac_isolate,
                ref_clk_enable}, rows[k].outs, "row controls");
        end
        rchk(5'h16, 16'hFFFF, "unanswered address");
        chk(restarts[15:0], 16'h0000, "restart while disabled");
        wr_at(`PBM_CTRL_OFFSET, 16'h1200);
        rchk(`PBM_CTRL_OFFSET, 16'h1200, "restart pending");
        wr_at(`PBM_CTRL_OFFSET, 16'h1000);
        chk({an_enable, restarts[14:0]}, 16'h8001, "restart count");
        @(posedge clk) an_started <= 1'h1;
        @(posedge clk) an_started <= 1'h0;
        rchk(`PBM_CTRL_OFFSET, 16'h1000, "restart cleared");
        @(posedge clk) irq_or_sleep_pin_n <= 1'h0;
        repeat (10) @(posedge clk);
        irq_or_sleep_pin_n <= 1'h1;
        rchk(`PBM_CTRL_OFFSET, 16'h1800, "pin power-down");
        chk(power_down, 16'h0001, "power-down level");
        wr_at(`PBM_CTRL_OFFSET, 16'h0080);
        chk(power_down, 16'h0000, "power-up");
        @(posedge clk) tx_en <= 1'h1;
        #1;
        for (int n = 0; n < `PBM_COL_ON_CYC && col !== 1'h1; n++) #8;
        chk(col, 16'h0001, "collision raised");
        @(posedge clk) tx_en <= 1'h0;
        repeat (`PBM_COL_OFF_CYC) @(posedge clk);
        #1;
        chk(col, 16'h0000, "collision dropped");
        wr_at(`PBM_CTRL_OFFSET, 16'h8000);
        rchk(`PBM_CTRL_OFFSET, 16'h3100, "after software reset");
        chk(sr_cycles[15:0], 16'h0010, "software reset length");
        @(posedge clk) rst <= 1'h1;
        negotiation_off_strap <= 1'h1;
        @(posedge clk) rst <= 1'h0;
        repeat (6) @(posedge clk);
        rchk(`PBM_CTRL_OFFSET, 16'h2100, "strap default");
        results();
    end
endmodule
`default_nettype wire
